// ### src/rdsa_defs.svh
// Register offsets, field positions and reset values of the daylight-saving block
`ifndef RDSA_DEFS_SVH
`define RDSA_DEFS_SVH
`define RDSA_OFS_FWD_MONTH  8'h15
`define RDSA_OFS_FWD_WD     8'h16
`define RDSA_OFS_FWD_DATE   8'h17
`define RDSA_OFS_FWD_HOUR   8'h18
`define RDSA_OFS_REV_MONTH  8'h19
`define RDSA_OFS_REV_WD     8'h1a
`define RDSA_OFS_REV_DATE   8'h1b
`define RDSA_OFS_REV_HOUR   8'h1c
`define RDSA_REG_RST        8'h00
`define RDSA_EN_BIT         7
`define RDSA_WKSEL_BIT      6
`define RDSA_WEEK_LSB       3
`define RDSA_WEEK_LAST      3'h7
`define RDSA_MONTH_MASK     8'h1f
`define RDSA_HOUR_MASK      8'h3f
`define RDSA_DAYS_PER_WEEK  5'h07
`define RDSA_HOUR_MAX       5'h17
`define RDSA_WDAY_MAX       3'h6
`define RDSA_MONTH_MAX      4'hc
`define RDSA_YEAR_MAX       7'h63
`endif

// ### src/rdsa_pkg.sv
// Types and BCD/calendar helpers of the daylight-saving block
package rdsa_pkg;
    typedef struct packed {
        logic [7:0] fwd_month;
        logic [7:0] fwd_wd;
        logic [7:0] fwd_date;
        logic [7:0] fwd_hour;
        logic [7:0] rev_month;
        logic [7:0] rev_wd;
        logic [7:0] rev_date;
        logic [7:0] rev_hour;
    } rdsa_cfg_t;

    typedef struct packed {
        rdsa_cfg_t  cfg;
        logic       done;
        logic [7:0] rdata;
        logic       load;
        logic [7:0] hour;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rdsa_state_t;

    function automatic logic [6:0] rdsa_bcd2bin(input logic [7:0] b);
        rdsa_bcd2bin = 7'({3'h0, b[7:4]} * 7'h0a + {3'h0, b[3:0]});
    endfunction : rdsa_bcd2bin

    function automatic logic [7:0] rdsa_bin2bcd(input logic [6:0] v);
        logic [6:0] tens;
        tens = v / 7'h0a;
        rdsa_bin2bcd = {tens[3:0], 4'(v - 7'(tens * 7'h0a))};
    endfunction : rdsa_bin2bcd

    // Years 00..99 map to 2000..2099, so every fourth year is leap
    function automatic logic [4:0] rdsa_mdays(input logic [3:0] m, input logic [6:0] y);
        unique case (m)
            4'h2:                   rdsa_mdays = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: rdsa_mdays = 5'h1e;
            default:                rdsa_mdays = 5'h1f;
        endcase
    endfunction : rdsa_mdays
endpackage : rdsa_pkg

// ### src/rdsa_time_step.sv
// One-hour step of the calendar, forward or back, with day/date/month/year carry
`timescale 1ns/1ps
`include "rdsa_defs.svh"
module rdsa_time_step (
    input  wire logic       fwd,
    input  wire logic [7:0] hour,
    input  wire logic [7:0] wday,
    input  wire logic [7:0] date,
    input  wire logic [7:0] month,
    input  wire logic [7:0] year,
    output logic      [7:0] n_hour,
    output logic      [7:0] n_wday,
    output logic      [7:0] n_date,
    output logic      [7:0] n_month,
    output logic      [7:0] n_year
);
    logic [4:0] h;
    logic [2:0] w;
    logic [4:0] d;
    logic [3:0] m;
    logic [6:0] y;

    always_comb begin
        h = 5'(rdsa_pkg::rdsa_bcd2bin(hour & `RDSA_HOUR_MASK));
        w = wday[2:0];
        d = 5'(rdsa_pkg::rdsa_bcd2bin(date));
        m = 4'(rdsa_pkg::rdsa_bcd2bin(month & `RDSA_MONTH_MASK));
        y = rdsa_pkg::rdsa_bcd2bin(year);
        if (fwd) begin
            if (h == `RDSA_HOUR_MAX) begin
                h = 5'h00;
                w = (w == `RDSA_WDAY_MAX) ? 3'h0 : 3'(w + 3'h1);
                if (d == rdsa_pkg::rdsa_mdays(m, y)) begin
                    d = 5'h01;
                    if (m == `RDSA_MONTH_MAX) begin
                        m = 4'h1;
                        y = (y == `RDSA_YEAR_MAX) ? 7'h00 : 7'(y + 7'h01);
                    end else begin
                        m = 4'(m + 4'h1);
                    end
                end else begin
                    d = 5'(d + 5'h01);
                end
            end else begin
                h = 5'(h + 5'h01);
            end
        end else begin
            if (h == 5'h00) begin
                h = `RDSA_HOUR_MAX;
                w = (w == 3'h0) ? `RDSA_WDAY_MAX : 3'(w - 3'h1);
                if (d == 5'h01) begin
                    if (m == 4'h1) begin
                        m = `RDSA_MONTH_MAX;
                        y = (y == 7'h00) ? `RDSA_YEAR_MAX : 7'(y - 7'h01);
                    end else begin
                        m = 4'(m - 4'h1);
                    end
                    d = rdsa_pkg::rdsa_mdays(m, y);
                end else begin
                    d = 5'(d - 5'h01);
                end
            end else begin
                h = 5'(h - 5'h01);
            end
        end
        n_hour  = rdsa_pkg::rdsa_bin2bcd({2'h0, h});
        n_wday  = {5'h00, w};
        n_date  = rdsa_pkg::rdsa_bin2bcd({2'h0, d});
        n_month = rdsa_pkg::rdsa_bin2bcd({3'h0, m});
        n_year  = rdsa_pkg::rdsa_bin2bcd(y);
    end
endmodule : rdsa_time_step

// ### src/rdsa_dst.sv
// Daylight-saving adjuster: rule registers, moment match, forward-done flag
`timescale 1ns/1ps
`include "rdsa_defs.svh"
// Contract
// - Step time forward at the forward moment and back at the reverse moment.
// - Rule registers persist, so the adjustment repeats every year.
// - Register 15h holds BCD month plus enable bit; 84h means April, enabled.
// - Register 16h holds week, weekday and week/day select; 48h is week 1 Sunday.
// - Date registers 17h and 1Bh are ignored when week/day matching is selected.
// - Hour registers 18h and 1Ch are plain BCD hours; 02h is 2 am.
// - Register 19h holds plain BCD month; 10h is October.
// - Register 1Ah week 7 means last week of month, four or five weeks.
// - Forward-done flag sets once the forward step is applied.
// - Flag clears on reverse step, on reset, and on writing enable to zero; a forward step in the same cycle as that write sets it instead.
module rdsa_dst (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       hour_tick,
    input  wire logic [7:0] cur_hour,
    input  wire logic [7:0] cur_wday,
    input  wire logic [7:0] cur_date,
    input  wire logic [7:0] cur_month,
    input  wire logic [7:0] cur_year,
    output logic      [7:0] reg_rdata,
    output logic            forward_done_flag,
    output logic            adj_load,
    output logic      [7:0] adj_hour,
    output logic      [7:0] adj_wday,
    output logic      [7:0] adj_date,
    output logic      [7:0] adj_month,
    output logic      [7:0] adj_year
);
    rdsa_pkg::rdsa_state_t st_r;
    rdsa_pkg::rdsa_state_t st_nxt;
    logic       [7:0]      s_hour;
    logic       [7:0]      s_wday;
    logic       [7:0]      s_date;
    logic       [7:0]      s_month;
    logic       [7:0]      s_year;
    logic                  en;
    logic                  fwd_hit;
    logic                  rev_hit;
    logic                  fwd_fire;
    logic                  rev_fire;

    // Current calendar against one programmed moment
    function automatic logic rule_hit(input logic [7:0] mon, input logic [7:0] wd,
                                      input logic [7:0] dt, input logic [7:0] hr);
        logic [4:0] d;
        logic [4:0] dim;
        logic [2:0] wk;
        logic       day_ok;
        d   = 5'(rdsa_pkg::rdsa_bcd2bin(cur_date));
        dim = rdsa_pkg::rdsa_mdays(4'(rdsa_pkg::rdsa_bcd2bin(cur_month & `RDSA_MONTH_MASK)),
                                   rdsa_pkg::rdsa_bcd2bin(cur_year));
        wk  = wd[`RDSA_WEEK_LSB +: 3];
        if (wd[`RDSA_WKSEL_BIT]) begin
            if (wk == `RDSA_WEEK_LAST)
                day_ok = ({1'b0, d} + {1'b0, `RDSA_DAYS_PER_WEEK}) > {1'b0, dim};
            else
                day_ok = 3'((5'(d - 5'h01) / `RDSA_DAYS_PER_WEEK) + 5'h01) == wk;
            day_ok = day_ok && (wd[2:0] == cur_wday[2:0]);
        end else begin
            day_ok = (dt == cur_date);
        end
        rule_hit = day_ok
                && ((mon & `RDSA_MONTH_MASK) == (cur_month & `RDSA_MONTH_MASK))
                && ((hr & `RDSA_HOUR_MASK) == (cur_hour & `RDSA_HOUR_MASK));
    endfunction : rule_hit

    // Direction follows the flag, so a repeated 1 am hour cannot re-trigger reverse
    rdsa_time_step u_step (
        .fwd     (~st_r.done),
        .hour    (cur_hour),
        .wday    (cur_wday),
        .date    (cur_date),
        .month   (cur_month),
        .year    (cur_year),
        .n_hour  (s_hour),
        .n_wday  (s_wday),
        .n_date  (s_date),
        .n_month (s_month),
        .n_year  (s_year)
    );

    always_comb begin
        en       = st_r.cfg.fwd_month[`RDSA_EN_BIT];
        fwd_hit  = rule_hit(st_r.cfg.fwd_month, st_r.cfg.fwd_wd,
                            st_r.cfg.fwd_date, st_r.cfg.fwd_hour);
        rev_hit  = rule_hit(st_r.cfg.rev_month, st_r.cfg.rev_wd,
                            st_r.cfg.rev_date, st_r.cfg.rev_hour);
        fwd_fire = hour_tick && en && !st_r.done && fwd_hit;
        rev_fire = hour_tick && en && st_r.done && rev_hit;
        st_nxt      = st_r;
        st_nxt.load = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                `RDSA_OFS_FWD_MONTH: begin
                    st_nxt.cfg.fwd_month = reg_wdata;
                    if (!reg_wdata[`RDSA_EN_BIT])
                        st_nxt.done = 1'b0;
                end
                `RDSA_OFS_FWD_WD:    st_nxt.cfg.fwd_wd    = reg_wdata;
                `RDSA_OFS_FWD_DATE:  st_nxt.cfg.fwd_date  = reg_wdata;
                `RDSA_OFS_FWD_HOUR:  st_nxt.cfg.fwd_hour  = reg_wdata;
                `RDSA_OFS_REV_MONTH: st_nxt.cfg.rev_month = reg_wdata;
                `RDSA_OFS_REV_WD:    st_nxt.cfg.rev_wd    = reg_wdata;
                `RDSA_OFS_REV_DATE:  st_nxt.cfg.rev_date  = reg_wdata;
                `RDSA_OFS_REV_HOUR:  st_nxt.cfg.rev_hour  = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `RDSA_OFS_FWD_MONTH: st_nxt.rdata = st_r.cfg.fwd_month;
                `RDSA_OFS_FWD_WD:    st_nxt.rdata = st_r.cfg.fwd_wd;
                `RDSA_OFS_FWD_DATE:  st_nxt.rdata = st_r.cfg.fwd_date;
                `RDSA_OFS_FWD_HOUR:  st_nxt.rdata = st_r.cfg.fwd_hour;
                `RDSA_OFS_REV_MONTH: st_nxt.rdata = st_r.cfg.rev_month;
                `RDSA_OFS_REV_WD:    st_nxt.rdata = st_r.cfg.rev_wd;
                `RDSA_OFS_REV_DATE:  st_nxt.rdata = st_r.cfg.rev_date;
                `RDSA_OFS_REV_HOUR:  st_nxt.rdata = st_r.cfg.rev_hour;
                default:             st_nxt.rdata = `RDSA_REG_RST;
            endcase
        end
        // Hardware set wins over a same-cycle disable write
        if (fwd_fire || rev_fire) begin
            st_nxt.load  = 1'b1;
            st_nxt.done  = fwd_fire;
            st_nxt.hour  = s_hour;
            st_nxt.wday  = s_wday;
            st_nxt.date  = s_date;
            st_nxt.month = s_month;
            st_nxt.year  = s_year;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata         = st_r.rdata;
    assign forward_done_flag = st_r.done;
    assign adj_load          = st_r.load;
    assign adj_hour          = st_r.hour;
    assign adj_wday          = st_r.wday;
    assign adj_date          = st_r.date;
    assign adj_month         = st_r.month;
    assign adj_year          = st_r.year;

    property p_fwd_step;
        @(posedge sys_clk) disable iff (rst)
        fwd_fire |=> adj_load && forward_done_flag;
    endproperty
    a_fwd_step: assert property (p_fwd_step) else $error("forward step missed");

    property p_rev_step;
        @(posedge sys_clk) disable iff (rst)
        rev_fire |=> adj_load && !forward_done_flag;
    endproperty
    a_rev_step: assert property (p_rev_step) else $error("reverse step missed");

    property p_disabled_quiet;
        @(posedge sys_clk) disable iff (rst)
        !st_r.cfg.fwd_month[`RDSA_EN_BIT] |=> !adj_load;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("step while off");

    property p_set_cause;
        @(posedge sys_clk) disable iff (rst)
        $rose(forward_done_flag) |-> adj_load && $past(hour_tick);
    endproperty
    a_set_cause: assert property (p_set_cause) else $error("flag set without step");

    property p_clr_on_disable;
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `RDSA_OFS_FWD_MONTH && !reg_wdata[`RDSA_EN_BIT] && !fwd_fire
            |=> !forward_done_flag;
    endproperty
    a_clr_on_disable: assert property (p_clr_on_disable) else $error("flag kept");

    property p_fwd_hour;
        @(posedge sys_clk) disable iff (rst)
        fwd_fire && (cur_hour & `RDSA_HOUR_MASK) != 8'h23
            |=> rdsa_pkg::rdsa_bcd2bin(adj_hour)
                == 7'(rdsa_pkg::rdsa_bcd2bin($past(cur_hour) & `RDSA_HOUR_MASK) + 7'h01);
    endproperty
    a_fwd_hour: assert property (p_fwd_hour) else $error("forward hour wrong");

    property p_rev_hour;
        @(posedge sys_clk) disable iff (rst)
        rev_fire && (cur_hour & `RDSA_HOUR_MASK) != 8'h00
            |=> rdsa_pkg::rdsa_bcd2bin(adj_hour)
                == 7'(rdsa_pkg::rdsa_bcd2bin($past(cur_hour) & `RDSA_HOUR_MASK) - 7'h01)
                && adj_date == $past(cur_date);
    endproperty
    a_rev_hour: assert property (p_rev_hour) else $error("reverse hour wrong");

    property p_cfg_kept;
        @(posedge sys_clk) disable iff (rst)
        !reg_wr |=> $stable(st_r.cfg);
    endproperty
    a_cfg_kept: assert property (p_cfg_kept) else $error("rules lost");

    property p_read_month;
        @(posedge sys_clk) disable iff (rst)
        reg_rd && !reg_wr && reg_addr == `RDSA_OFS_FWD_MONTH
            |=> reg_rdata == $past(st_r.cfg.fwd_month)
                ##1 ($past(reg_rd) || reg_rdata == $past(reg_rdata));
    endproperty
    a_read_month: assert property (p_read_month) else $error("read back wrong");

    c_fwd: cover property (@(posedge sys_clk) disable iff (rst) fwd_fire);
    c_rev: cover property (@(posedge sys_clk) disable iff (rst) rev_fire);
    c_last: cover property (@(posedge sys_clk) disable iff (rst)
        rev_fire && st_r.cfg.rev_wd[`RDSA_WEEK_LSB +: 3] == `RDSA_WEEK_LAST);
endmodule : rdsa_dst

// ### testbench/rdsa_timekeeper_model.sv
// Timekeeper model: holds the calendar, raises hour ticks, loads stepped time
`timescale 1ns/1ps
module rdsa_timekeeper_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        set_stb,
    input  wire logic [39:0] set_time,
    input  wire logic        tick_req,
    input  wire logic        adj_load,
    input  wire logic [39:0] adj_time,
    output logic             hour_tick,
    output logic      [39:0] cur_time
);
    // Calendar packed as hour, weekday, date, month, year
    assign hour_tick = tick_req;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_time <= 40'h00_00_01_01_00;
        end else if (adj_load) begin
            // Load wins over a host set, as the stepped time is newer
            cur_time <= adj_time;
        end else if (set_stb) begin
            cur_time <= set_time;
        end
    end
endmodule : rdsa_timekeeper_model

// ### testbench/tb_rdsa_dst.sv
// Testbench of the daylight-saving adjuster
`timescale 1ns/1ps
`include "rdsa_defs.svh"
module tb_rdsa_dst;
    logic             sys_clk = 1'b0;
    logic             rst = 1'b1;
    logic             reg_wr = 1'b0;
    logic             reg_rd = 1'b0;
    logic      [7:0]  reg_addr = 8'h00;
    logic      [7:0]  reg_wdata = 8'h00;
    logic             set_stb = 1'b0;
    logic             tick_req = 1'b0;
    logic      [39:0] set_time = 40'h0;
    wire logic        hour_tick;
    wire logic [39:0] cur_time;
    wire logic [39:0] adj_time;
    logic      [7:0]  reg_rdata;
    logic             forward_done_flag;
    logic             adj_load;
    int               fails = 0;
    int               compares = 0;
    int               cycles = 0;
    logic      [7:0]  tab_d [8] = '{8'h84, 8'h48, 8'h00, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02};

    always #4 sys_clk = ~sys_clk;

    rdsa_timekeeper_model rdsa_timekeeper_model_inst (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .set_stb   (set_stb),
        .set_time  (set_time),
        .tick_req  (tick_req),
        .adj_load  (adj_load),
        .adj_time  (adj_time),
        .hour_tick (hour_tick),
        .cur_time  (cur_time)
    );

    rdsa_dst rdsa_dst_inst (
        .sys_clk           (sys_clk),
        .rst               (rst),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .hour_tick         (hour_tick),
        .cur_hour          (cur_time[39:32]),
        .cur_wday          (cur_time[31:24]),
        .cur_date          (cur_time[23:16]),
        .cur_month         (cur_time[15:8]),
        .cur_year          (cur_time[7:0]),
        .reg_rdata         (reg_rdata),
        .forward_done_flag (forward_done_flag),
        .adj_load          (adj_load),
        .adj_hour          (adj_time[39:32]),
        .adj_wday          (adj_time[31:24]),
        .adj_date          (adj_time[23:16]),
        .adj_month         (adj_time[15:8]),
        .adj_year          (adj_time[7:0])
    );

    task automatic tally_and_finish();
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        check({32'h0, reg_rdata}, {32'h0, e});
    endtask : rd

    // Set the calendar, pulse one hour tick, check load, stepped time and flag
    task automatic tick(input logic [39:0] t, input logic el, input logic [39:0] et,
                        input logic ef);
        @(negedge sys_clk);
        set_time = t;
        set_stb = 1'b1;
        @(negedge sys_clk);
        set_stb = 1'b0;
        tick_req = 1'b1;
        @(negedge sys_clk);
        tick_req = 1'b0;
        check({39'h0, adj_load}, {39'h0, el});
        @(negedge sys_clk);
        check(cur_time, et);
        check({39'h0, forward_done_flag}, {39'h0, ef});
    endtask : tick

    // Whole run is about 134 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        check({39'h0, forward_done_flag}, 40'h0);
        for (int i = 0; i < 8; i++) begin
            rd(8'(`RDSA_OFS_FWD_MONTH + i), `RDSA_REG_RST);
        end
        wr(8'h1d, 8'hff);
        rd(8'h1d, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(8'(`RDSA_OFS_FWD_MONTH + i), tab_d[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(8'(`RDSA_OFS_FWD_MONTH + i), tab_d[i]);
        end
        tick(40'h02_00_01_04_24, 1'b1, 40'h03_00_01_04_24, 1'b1);
        tick(40'h02_00_01_04_24, 1'b0, 40'h02_00_01_04_24, 1'b1);
        tick(40'h02_00_20_10_24, 1'b0, 40'h02_00_20_10_24, 1'b1);
        tick(40'h02_00_27_10_24, 1'b1, 40'h01_00_27_10_24, 1'b0);
        tick(40'h02_00_06_04_25, 1'b1, 40'h03_00_06_04_25, 1'b1);
        tick(40'h02_00_29_10_25, 1'b1, 40'h01_00_29_10_25, 1'b0);
        tick(40'h02_00_01_04_26, 1'b1, 40'h03_00_01_04_26, 1'b1);
        wr(`RDSA_OFS_FWD_MONTH, 8'h04);
        @(negedge sys_clk);
        check({39'h0, forward_done_flag}, 40'h0);
        tick(40'h02_00_05_04_26, 1'b0, 40'h02_00_05_04_26, 1'b0);
        // Date matching, stepping across day, month and leap February
        wr(`RDSA_OFS_FWD_MONTH, 8'h84);
        wr(`RDSA_OFS_FWD_WD, 8'h00);
        wr(`RDSA_OFS_FWD_DATE, 8'h30);
        wr(`RDSA_OFS_FWD_HOUR, 8'h23);
        wr(`RDSA_OFS_REV_MONTH, 8'h03);
        wr(`RDSA_OFS_REV_WD, 8'h00);
        wr(`RDSA_OFS_REV_DATE, 8'h01);
        wr(`RDSA_OFS_REV_HOUR, 8'h00);
        rd(`RDSA_OFS_FWD_HOUR, 8'h23);
        rd(`RDSA_OFS_REV_MONTH, 8'h03);
        tick(40'h23_06_30_04_25, 1'b1, 40'h00_00_01_05_25, 1'b1);
        tick(40'h00_05_01_03_24, 1'b1, 40'h23_04_29_02_24, 1'b0);
        // Second week, Wednesday: date 7 is still week one, date 8 is week two
        wr(`RDSA_OFS_FWD_WD, 8'h53);
        tick(40'h23_03_07_04_25, 1'b0, 40'h23_03_07_04_25, 1'b0);
        tick(40'h23_03_08_04_25, 1'b1, 40'h00_04_09_04_25, 1'b1);
        // Power-up clears the flag and the rule registers
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        check({39'h0, forward_done_flag}, 40'h0);
        rd(`RDSA_OFS_FWD_MONTH, `RDSA_REG_RST);
        tally_and_finish();
    end
endmodule : tb_rdsa_dst
